// >>> common/clock_source_regs.vh
// Purpose: register map, reset values and timing constants of the clock source selector
// Assumes: 50 MHz system clock, AHB-Lite word registers
// Notes:   definitions only
`ifndef CLOCK_SOURCE_REGS_VH
`define CLOCK_SOURCE_REGS_VH

`define CLK_FREQ_MHZ      50
// register byte offsets (low address byte)
`define OFS_CTRL1         8'h00
`define OFS_CTRL2         8'h04
`define OFS_TRIM          8'h08
`define OFS_STATUS        8'h0C
// ctrl1 fields
`define C1_CLOCK_SOURCE_SELECT_LSB       0
`define C1_CLOCK_SOURCE_SELECT_MSB       1
`define C1_REFS           2
`define C1_RDIV_LSB       3
`define C1_RDIV_MSB       5
// ctrl2 fields
`define C2_BUS_CLOCK_DIVIDE_SELECT_LSB       0
`define C2_BUS_CLOCK_DIVIDE_SELECT_MSB       2
`define C2_LP             3
`define C2_LOCK_IE        4
`define C2_MON_EN         5
// status fields
`define ST_CLKST_LSB      0
`define ST_CLKST_MSB      1
`define ST_REFST          2
`define ST_LOCK           3
`define ST_LOLS           4
`define ST_EXT_LOST       5
// reset values: loop engaged, internal reference
`define RST_CLOCK_SOURCE_SELECT          2'h0
`define RST_REFS          1'h1
`define RST_RDIV          3'h0
`define RST_BUS_CLOCK_DIVIDE_SELECT          3'h1
`define RST_TRIM          9'h100
// clock source select encodings
`define SRC_LOOP          2'h0
`define SRC_INT           2'h1
`define SRC_EXT           2'h2
// internal reference period in system clocks is base plus trim plus one
`define IREF_BASE         11'h500
// loop targets 512 oscillator ticks per reference period
`define LOOP_MULT         11'h200
`define LOOP_GAIN_SHIFT   5
`define LOCK_TOL          12'h002
`define LOCK_PERIODS      3'h4
// oscillator control word: tick rate = word / 65536 * 50 MHz, 16 to 20 MHz
`define FCW_MIN           16'h51EC
`define FCW_MAX           16'h6666
`define FCW_RST           16'h5555
// external clock loss time and low power oscillator rate
`define EXT_LOSS_TIME_US  100
`define LPO_FREQ_KHZ      1

`endif

// >>> logic/fll_clock_source_selector.v
// Purpose: clock generation and selection with frequency-locked loop, bus divider, monitors
// Assumes: all produced clocks are one-cycle enable pulses on clk; AHB-Lite register slave
// Notes:   the external oscillator arrives asynchronously on ext_osc_in
`include "clock_source_regs.vh"

module fll_clock_source_selector #(
  parameter EXT_LOSS_CYCLES = `EXT_LOSS_TIME_US * `CLK_FREQ_MHZ,
  parameter LPO_DIV_CYCLES  = (`CLK_FREQ_MHZ * 1000) / `LPO_FREQ_KHZ
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        ext_osc_in,
  input  wire        debug_active,
  output reg         system_clock_out,
  output reg         selected_clock_output,
  output reg         debug_clock_out,
  output reg         ext_clock_out,
  output reg         lpo_1khz_tick,
  output wire        lock_irq,
  output wire        ext_loss_reset_req
);

  ////////////////////////////////////////////////////////////////////////
  // registers and bus slave
  reg  [1:0]  clock_source_select_q;
  reg         reference_select_q;
  reg  [2:0]  rdiv_q;
  reg  [2:0]  bus_clock_divide_select_q;
  reg         loop_low_power_disable_q;
  reg         lock_ie_q;
  reg         mon_en_q;
  reg  [8:0]  trim_q;
  reg  [1:0]  clkst_q;
  reg         locked_q;
  reg         lock_lost_q;
  reg         ext_lost_q;
  reg         wr_q;
  reg  [7:0]  wa_q;

  wire        take = hsel & htrans[1] & hready;
  wire        wr_c1 = wr_q & (wa_q == `OFS_CTRL1);
  wire        wr_c2 = wr_q & (wa_q == `OFS_CTRL2);
  wire        wr_tr = wr_q & (wa_q == `OFS_TRIM);
  wire        wr_st = wr_q & (wa_q == `OFS_STATUS);
  wire        lock_lost_set;

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_q <= take & hwrite;
      wa_q <= haddr[7:0];
      if (take & ~hwrite) begin
        if (haddr[7:0] == `OFS_CTRL1) begin
          hrdata <= {26'h0000000, rdiv_q, reference_select_q, clock_source_select_q};
        end else if (haddr[7:0] == `OFS_CTRL2) begin
          hrdata <= {26'h0000000, mon_en_q, lock_ie_q, loop_low_power_disable_q,
                     bus_clock_divide_select_q};
        end else if (haddr[7:0] == `OFS_TRIM) begin
          hrdata <= {23'h000000, trim_q};
        end else if (haddr[7:0] == `OFS_STATUS) begin
          hrdata <= {26'h0000000, ext_lost_q, lock_lost_q, locked_q, reference_select_q, clkst_q};
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_source_select_q     <= `RST_CLOCK_SOURCE_SELECT;
      reference_select_q        <= `RST_REFS;
      rdiv_q                    <= `RST_RDIV;
      bus_clock_divide_select_q <= `RST_BUS_CLOCK_DIVIDE_SELECT;
      loop_low_power_disable_q  <= 1'b0;
      lock_ie_q                 <= 1'b0;
      mon_en_q                  <= 1'b0;
      trim_q                    <= `RST_TRIM;
      lock_lost_q               <= 1'b0;
    end else begin
      if (wr_c1) begin
        clock_source_select_q <= hwdata[`C1_CLOCK_SOURCE_SELECT_MSB:`C1_CLOCK_SOURCE_SELECT_LSB];
        reference_select_q    <= hwdata[`C1_REFS];
        rdiv_q                <= hwdata[`C1_RDIV_MSB:`C1_RDIV_LSB];
      end
      if (wr_c2) begin
        bus_clock_divide_select_q <= hwdata[`C2_BUS_CLOCK_DIVIDE_SELECT_MSB:`C2_BUS_CLOCK_DIVIDE_SELECT_LSB];
        loop_low_power_disable_q  <= hwdata[`C2_LP];
        lock_ie_q                 <= hwdata[`C2_LOCK_IE];
        mon_en_q                  <= hwdata[`C2_MON_EN];
      end
      if (wr_tr) begin
        trim_q <= hwdata[8:0];
      end
      // hardware set wins over a write-one clear in the same cycle
      if (lock_lost_set) begin
        lock_lost_q <= 1'b1;
      end else if (wr_st & hwdata[`ST_LOLS]) begin
        lock_lost_q <= 1'b0;
      end
    end
  end

  assign lock_irq = lock_lost_q & lock_ie_q;

  ////////////////////////////////////////////////////////////////////////
  // source selection
  wire ext_ok = ~ext_lost_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkst_q <= `SRC_LOOP;
    end else if ((clock_source_select_q == `SRC_LOOP) || (clock_source_select_q == `SRC_INT) ||
                 ((clock_source_select_q == `SRC_EXT) && ext_ok)) begin
      clkst_q <= clock_source_select_q;
    end
  end

  // loop sleeps only when bypassed, low-power set and no debug session
  wire loop_on = (clkst_q == `SRC_LOOP) | ~loop_low_power_disable_q | debug_active;

  ////////////////////////////////////////////////////////////////////////
  // external oscillator: synchroniser, edge, monitor, reference divider
  reg        ext_s1_q;
  reg        ext_s2_q;
  reg        ext_s3_q;
  reg [15:0] ext_idle_q;
  reg [6:0]  rdiv_cnt_q;
  reg        ext_ref_tick_q;

  wire ext_edge = ext_s2_q & ~ext_s3_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_s1_q       <= 1'b0;
      ext_s2_q       <= 1'b0;
      ext_s3_q       <= 1'b0;
      ext_idle_q     <= 16'h0000;
      ext_lost_q     <= 1'b1;
      rdiv_cnt_q     <= 7'h00;
      ext_ref_tick_q <= 1'b0;
      ext_clock_out  <= 1'b0;
    end else begin
      ext_s1_q      <= ext_osc_in;
      ext_s2_q      <= ext_s1_q;
      ext_s3_q      <= ext_s2_q;
      ext_clock_out <= ext_edge;
      if (ext_edge) begin
        ext_idle_q <= 16'h0000;
        ext_lost_q <= 1'b0;
      end else if (ext_idle_q >= EXT_LOSS_CYCLES[15:0]) begin
        ext_lost_q <= 1'b1;
      end else begin
        ext_idle_q <= ext_idle_q + 16'h0001;
      end
      // divide by 2^rdiv before feeding the loop
      ext_ref_tick_q <= 1'b0;
      if (ext_edge) begin
        if (rdiv_cnt_q >= ((7'h01 << rdiv_q) - 7'h01)) begin
          rdiv_cnt_q     <= 7'h00;
          ext_ref_tick_q <= 1'b1;
        end else begin
          rdiv_cnt_q <= rdiv_cnt_q + 7'h01;
        end
      end
    end
  end

  wire ext_in_use = ~reference_select_q | (clkst_q == `SRC_EXT);
  assign ext_loss_reset_req = mon_en_q & ext_in_use & ext_lost_q;

  ////////////////////////////////////////////////////////////////////////
  // internal reference and low power oscillator
  reg [10:0] iref_cnt_q;
  reg        iref_tick_q;
  reg [15:0] lpo_cnt_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iref_cnt_q    <= 11'h000;
      iref_tick_q   <= 1'b0;
      lpo_cnt_q     <= 16'h0000;
      lpo_1khz_tick <= 1'b0;
    end else begin
      // a larger trim lengthens the period
      iref_tick_q <= 1'b0;
      if (iref_cnt_q >= (`IREF_BASE + {2'b00, trim_q})) begin
        iref_cnt_q  <= 11'h000;
        iref_tick_q <= 1'b1;
      end else begin
        iref_cnt_q <= iref_cnt_q + 11'h001;
      end
      lpo_1khz_tick <= 1'b0;
      if (lpo_cnt_q >= (LPO_DIV_CYCLES[15:0] - 16'h0001)) begin
        lpo_cnt_q     <= 16'h0000;
        lpo_1khz_tick <= 1'b1;
      end else begin
        lpo_cnt_q <= lpo_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator and frequency-locked loop
  reg  [15:0] fcw_q;
  reg  [15:0] acc_q;
  reg         dco_tick_q;
  reg         half_q;
  reg  [10:0] tick_cnt_q;
  reg  [2:0]  good_q;

  wire        ref_tick = reference_select_q ? iref_tick_q : ext_ref_tick_q;
  wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, fcw_q};
  wire signed [11:0] ferr = $signed({1'b0, `LOOP_MULT}) - $signed({1'b0, tick_cnt_q});
  wire signed [17:0] fnext = $signed({2'b00, fcw_q}) + ($signed({{6{ferr[11]}}, ferr}) <<< `LOOP_GAIN_SHIFT);
  wire        in_tol = (ferr <= $signed(`LOCK_TOL)) && (ferr >= -$signed(`LOCK_TOL));
  assign lock_lost_set = loop_on & ref_tick & locked_q & ~in_tol;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fcw_q      <= `FCW_RST;
      acc_q      <= 16'h0000;
      dco_tick_q <= 1'b0;
      half_q     <= 1'b0;
      tick_cnt_q <= 11'h000;
      good_q     <= 3'h0;
      locked_q   <= 1'b0;
    end else if (!loop_on) begin
      dco_tick_q <= 1'b0;
      tick_cnt_q <= 11'h000;
      good_q     <= 3'h0;
      locked_q   <= 1'b0;
    end else begin
      acc_q      <= acc_sum[15:0];
      dco_tick_q <= acc_sum[16];
      if (dco_tick_q) begin
        half_q <= ~half_q;
      end
      if (ref_tick) begin
        tick_cnt_q <= 11'h000;
        // clamp keeps the oscillator in its band
        if (fnext < $signed({2'b00, `FCW_MIN})) begin
          fcw_q <= `FCW_MIN;
        end else if (fnext > $signed({2'b00, `FCW_MAX})) begin
          fcw_q <= `FCW_MAX;
        end else begin
          fcw_q <= fnext[15:0];
        end
        if (!in_tol) begin
          good_q   <= 3'h0;
          locked_q <= 1'b0;
        end else if (good_q >= `LOCK_PERIODS) begin
          locked_q <= 1'b1;
        end else begin
          good_q <= good_q + 3'h1;
        end
      end else if ((tick_cnt_q != 11'h7FF) && dco_tick_q) begin
        tick_cnt_q <= tick_cnt_q + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output selection and bus divider
  reg  [6:0] bus_clock_divide_select_cnt_q;
  reg        src_tick;
  reg        last_tick_q;
  wire [6:0] bus_clock_divide_select_mask = (7'h01 << bus_clock_divide_select_q) - 7'h01;
  // a source switch can join ticks of two sources back to back: the second is dropped
  wire       src_clean = src_tick & ~last_tick_q;

  always @* begin
    case (clkst_q)
      `SRC_INT: src_tick = iref_tick_q;
      `SRC_EXT: src_tick = ext_edge;
      default:  src_tick = dco_tick_q;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_clock_divide_select_cnt_q            <= 7'h00;
      last_tick_q           <= 1'b0;
      system_clock_out      <= 1'b0;
      selected_clock_output <= 1'b0;
      debug_clock_out       <= 1'b0;
    end else begin
      last_tick_q           <= src_tick;
      selected_clock_output <= src_clean;
      debug_clock_out       <= loop_on & dco_tick_q & half_q;
      // mask compare: a new ratio acts on the very next source tick
      system_clock_out <= src_clean & ((bus_clock_divide_select_cnt_q & bus_clock_divide_select_mask) == bus_clock_divide_select_mask);
      if (src_clean) begin
        bus_clock_divide_select_cnt_q <= bus_clock_divide_select_cnt_q + 7'h01;
      end
    end
  end

endmodule // fll_clock_source_selector

// >>> bench/clock_selector_chk.sv
// Purpose: port-level assertions for the clock source selector
// Assumes: one clock domain, rstn async active low
// Notes:   bound into every instance of the top module
module clock_selector_chk #(
  parameter EXT_LOSS_CYCLES = 200,
  parameter LPO_DIV_CYCLES  = 50
) (
  input wire clk,
  input wire rstn,
  input wire ext_osc_in,
  input wire system_clock_out,
  input wire selected_clock_output,
  input wire debug_clock_out,
  input wire ext_clock_out,
  input wire lpo_1khz_tick,
  input wire lock_irq,
  input wire ext_loss_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  logic        seen_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // the first period after reset is not checked: its start phase is open
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (lpo_1khz_tick) begin
      cnt_q  <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
    end
  end
  chk_sys_divided: assert property (
    system_clock_out |-> selected_clock_output) else $error("system tick without source tick");
  chk_sel_gap: assert property (
    selected_clock_output |=> !selected_clock_output) else $error("source ticks back to back");
  chk_dbg_half: assert property (
    debug_clock_out |=> !debug_clock_out [*3]) else $error("debug tick faster than half rate");
  chk_lpo_period: assert property (
    seen_q && lpo_1khz_tick |-> cnt_q == LPO_DIV_CYCLES - 1) else $error("slow tick period wrong");
  chk_ext_cause: assert property (
    ext_clock_out |-> $past(ext_osc_in, 1) || $past(ext_osc_in, 2) || $past(ext_osc_in, 3)
      || $past(ext_osc_in, 4)) else $error("ext tick without ext edge");
  chk_ext_clears: assert property (
    ext_clock_out |=> !ext_loss_reset_req) else $error("reset request with ext running");
  chk_irq_idle: assert property (
    $rose(rstn) |-> !lock_irq) else $error("lock irq set out of reset");
  chk_req_idle: assert property (
    $rose(rstn) |-> !ext_loss_reset_req [*2]) else $error("monitor request out of reset");
  cover property (system_clock_out);
  cover property (debug_clock_out);
  cover property (ext_loss_reset_req);
endmodule // clock_selector_chk

bind fll_clock_source_selector clock_selector_chk #(
  .EXT_LOSS_CYCLES(EXT_LOSS_CYCLES), .LPO_DIV_CYCLES(LPO_DIV_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .ext_osc_in(ext_osc_in), .system_clock_out(system_clock_out),
  .selected_clock_output(selected_clock_output), .debug_clock_out(debug_clock_out),
  .ext_clock_out(ext_clock_out), .lpo_1khz_tick(lpo_1khz_tick), .lock_irq(lock_irq),
  .ext_loss_reset_req(ext_loss_reset_req));

// >>> bench/clock_consumer_model.sv
// Purpose: consumer of the system clock enables, measures divide ratio
// Assumes: enables are one-cycle pulses on clk
// Notes:   ratio_q counts source ticks per system tick, sys tick included
module clock_consumer_model (
  input  wire        clk,
  input  wire        rstn,
  input  wire        system_clock_out,
  input  wire        selected_clock_output,
  input  wire        debug_clock_out,
  output logic [15:0] sys_cnt_q,
  output logic [15:0] dbg_cnt_q,
  output logic [8:0]  ratio_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] run_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_cnt_q <= 16'h0000;
      dbg_cnt_q <= 16'h0000;
      ratio_q   <= 9'h000;
      run_q     <= 9'h000;
    end else begin
      if (debug_clock_out) dbg_cnt_q <= dbg_cnt_q + 16'h0001;
      if (system_clock_out) begin
        sys_cnt_q <= sys_cnt_q + 16'h0001;
        ratio_q   <= run_q + 9'h001;
        run_q     <= 9'h000;
      end else if (selected_clock_output) begin
        run_q     <= run_q + 9'h001;
      end
    end
  end
endmodule // clock_consumer_model

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the clock source selector
// Assumes: 50 MHz clk, AHB-Lite single word transfers
// Notes:   small loss and slow-tick counts keep the run short
`include "clock_source_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] c1; logic [31:0] c2; logic [31:0] ratio; logic [31:0] clkst;} row_t;
  logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_osc_in = 1'b0, debug_active = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0, ext_div = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        ext_run = 1'b1;
  wire         hreadyout, hresp, sys_o, sel_o, dbg_o, ext_o, lpo_o, irq_o, req_o;
  wire  [31:0] hrdata;
  wire  [15:0] sys_cnt_q, dbg_cnt_q;
  wire  [8:0]  ratio_q;
  int          num_errors = 0, cmp_count = 0;
  row_t rows[10] = '{'{32'h6, 32'h0, 32'h1, 32'h2}, '{32'h6, 32'h1, 32'h2, 32'h2},
    '{32'h6, 32'h2, 32'h4, 32'h2}, '{32'h6, 32'h3, 32'h8, 32'h2}, '{32'h6, 32'h4, 32'h10, 32'h2},
    '{32'h6, 32'h5, 32'h20, 32'h2}, '{32'h6, 32'h6, 32'h40, 32'h2}, '{32'h6, 32'h7, 32'h80, 32'h2},
    '{32'h4, 32'h3, 32'h8, 32'h0}, '{32'h5, 32'h0, 32'h1, 32'h1}};
  always #10 clk = ~clk;
  // stoppable external oscillator, one period every 8 clocks
  always @(posedge clk) if (ext_run) begin
    ext_div <= ext_div + 2'h1;
    if (ext_div == 2'h3) ext_osc_in <= ~ext_osc_in;
  end
  fll_clock_source_selector #(.EXT_LOSS_CYCLES(200), .LPO_DIV_CYCLES(50)) u_fll_clock_source_selector (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_osc_in(ext_osc_in), .debug_active(debug_active), .system_clock_out(sys_o),
    .selected_clock_output(sel_o), .debug_clock_out(dbg_o), .ext_clock_out(ext_o),
    .lpo_1khz_tick(lpo_o), .lock_irq(irq_o), .ext_loss_reset_req(req_o));
  clock_consumer_model u_clock_consumer_model (.clk(clk), .rstn(rstn), .system_clock_out(sys_o),
    .selected_clock_output(sel_o), .debug_clock_out(dbg_o), .sys_cnt_q(sys_cnt_q),
    .dbg_cnt_q(dbg_cnt_q), .ratio_q(ratio_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
  endtask
  // idle cycles after each transfer let status follow a landed write
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_sys(input int k);
    logic [15:0] s;
    int t;
    s = sys_cnt_q;
    t = 0;
    while (int'(sys_cnt_q - s) < k && t < 8000) begin
      t++;
      @(posedge clk);
    end
    if (t >= 8000) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic dbg_check(input logic [31:0] e);
    logic [15:0] d0;
    d0 = dbg_cnt_q;
    repeat (200) @(posedge clk);
    cmp("debug_clock_running", e, {31'h0, dbg_cnt_q != d0});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    ahb(0, `OFS_CTRL1, 0); cmp("ctrl1_rst", 32'h4, rd);
    cmp("hresp_okay", 32'h0, {31'h0, hresp});
    ahb(0, `OFS_CTRL2, 0); cmp("ctrl2_rst", 32'h1, rd);
    ahb(0, `OFS_TRIM, 0); cmp("trim_rst", 32'h100, rd);
    ahb(0, `OFS_STATUS, 0); cmp("status_rst", 32'h4, rd & 32'h7);
    ahb(1, `OFS_TRIM, 32'hFFFFFFFF); ahb(0, `OFS_TRIM, 0); cmp("trim_width", 32'h1FF, rd);
    ahb(1, 8'h10, 32'hFFFFFFFF); ahb(0, 8'h10, 0); cmp("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      ahb(1, `OFS_CTRL1, rows[i].c1);
      ahb(1, `OFS_CTRL2, rows[i].c2);
      wait_sys(2);
      cmp("divide_ratio", rows[i].ratio, {23'h0, ratio_q});
      ahb(0, `OFS_STATUS, 0); cmp("clkst", rows[i].clkst, rd & 32'h3);
    end
    ahb(1, `OFS_CTRL2, 32'h8); dbg_check(32'h0);
    debug_active <= 1'b1;
    dbg_check(32'h1);
    debug_active <= 1'b0;
    ahb(1, `OFS_CTRL2, 32'h0); dbg_check(32'h1);
    ahb(1, `OFS_CTRL1, 32'h4); ahb(1, `OFS_CTRL2, 32'h8); dbg_check(32'h1);
    ahb(1, `OFS_CTRL1, 32'h6); ahb(1, `OFS_CTRL2, 32'h20);
    ext_run <= 1'b0;
    repeat (260) @(posedge clk);
    cmp("loss_request", 32'h1, {31'h0, req_o});
    ahb(0, `OFS_STATUS, 0); cmp("ext_lost", 32'h20, rd & 32'h20);
    ahb(1, `OFS_CTRL1, 32'h5); cmp("loss_request_int", 32'h0, {31'h0, req_o});
    ahb(1, `OFS_CTRL1, 32'h6); ahb(0, `OFS_STATUS, 0); cmp("keep_int", 32'h1, rd & 32'h3);
    ahb(1, `OFS_CTRL1, 32'h7); ahb(0, `OFS_STATUS, 0); cmp("reject_11", 32'h1, rd & 32'h3);
    ext_run <= 1'b1;
    repeat (20) @(posedge clk);
    ahb(1, `OFS_CTRL1, 32'h6); ahb(0, `OFS_STATUS, 0); cmp("ext_back", 32'h2, rd & 32'h3);
    // a mid trim puts 512 oscillator ticks per reference period inside the band
    ahb(1, `OFS_TRIM, 32'h100); ahb(1, `OFS_CTRL1, 32'h4); ahb(1, `OFS_CTRL2, 32'h10);
    rd = 32'h0;
    for (int i = 0; i < 30 && rd[3] !== 1'b1; i++) begin
      repeat (1000) @(posedge clk);
      ahb(0, `OFS_STATUS, 0);
    end
    cmp("loop_locked", 32'h8, rd & 32'h8);
    cmp("lock_irq_idle", 32'h0, {31'h0, irq_o});
    // the longest trim needs a rate below the band, so lock is lost
    ahb(1, `OFS_TRIM, 32'h1FF);
    repeat (4000) @(posedge clk);
    cmp("lock_irq", 32'h1, {31'h0, irq_o});
    ahb(0, `OFS_STATUS, 0); cmp("lock_lost", 32'h10, rd & 32'h18);
    ahb(1, `OFS_STATUS, 32'h10); cmp("lock_irq_clr", 32'h0, {31'h0, irq_o});
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    ahb(0, `OFS_CTRL1, 0); cmp("ctrl1_rerst", 32'h4, rd);
    test_done();
  end
endmodule // tb_top
